// ### hdl/auto_reload_timer.sv
`timescale 1ns/100ps
module auto_reload_timer
  import reload_timer_pkg::*;
#(
  parameter int PRESCALE_DIV = SYS_PRESCALE_DIV,
  parameter int EXT_DIV = EXT_CLOCK_DIV
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // external oscillator input
  input wire logic ext_osc,
  // events
  output logic overflow_pulse,
  output logic overflow_flag
);

  // refuse dividers that the 8-bit prescale counters cannot serve
  if (PRESCALE_DIV < 2 || PRESCALE_DIV > 255 ||
      EXT_DIV < 2 || EXT_DIV > 255) begin : g_bad_div
    $error("auto_reload_timer: divider out of range");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] count_ff, nxt_count;
  logic [7:0] reload_low_byte_ff, nxt_reload_low_byte;
  logic [7:0] reload_high_byte_ff, nxt_reload_high_byte;
  logic overflow_flag_ff, nxt_overflow_flag;
  logic run_control_ff, nxt_run_control;
  logic prescale_select_ff, nxt_prescale_select;
  logic external_clock_select_ff, nxt_external_clock_select;
  logic [7:0] div12_ff, nxt_div12;
  logic [7:0] div8_ff, nxt_div8;
  logic osc_meta_ff, osc_sync_ff, osc_prev_ff;
  logic overflow_pulse_ff, nxt_overflow_pulse;
  logic [7:0] rdata_ff, nxt_rdata;

  logic wr_ctrl, wr_cnt_lo, wr_cnt_hi, osc_rise, div12_tick, ext_tick, tick, wrap;
  logic [7:0] ctrl_view;

  // ----------------------------------------------------------------
  // oscillator input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end else begin
      osc_meta_ff <= ext_osc;
      osc_sync_ff <= osc_meta_ff;
      osc_prev_ff <= osc_sync_ff;
    end
  end

  assign osc_rise = osc_sync_ff & ~osc_prev_ff;
  assign wr_ctrl = sfr_wr && sfr_addr == ADDR_CONTROL;
  assign wr_cnt_lo = sfr_wr && sfr_addr == ADDR_COUNT_LOW;
  assign wr_cnt_hi = sfr_wr && sfr_addr == ADDR_COUNT_HIGH;
  assign div12_tick = div12_ff == 8'(PRESCALE_DIV - 1);
  assign ext_tick = osc_rise && div8_ff == 8'(EXT_DIV - 1);
  // time base only; nothing counts pin events
  assign tick = external_clock_select_ff ? ext_tick :
                (prescale_select_ff ? 1'b1 : div12_tick);
  assign wrap = run_control_ff && tick && count_ff == 16'hFFFF;
  assign ctrl_view = {overflow_flag_ff, 4'h0, run_control_ff, prescale_select_ff,
                      external_clock_select_ff};

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_div12 = div12_tick ? 8'h00 : div12_ff + 8'h01;
    nxt_div8 = div8_ff;
    if (osc_rise) begin
      nxt_div8 = (div8_ff == 8'(EXT_DIV - 1)) ? 8'h00 : div8_ff + 8'h01;
    end
    nxt_count = count_ff;
    if (run_control_ff && tick) begin
      nxt_count = wrap ? {reload_high_byte_ff, reload_low_byte_ff} :
                  count_ff + 16'h0001;
    end
    if (wr_cnt_lo) begin
      nxt_count[7:0] = sfr_wdata;
    end
    if (wr_cnt_hi) begin
      nxt_count[15:8] = sfr_wdata;
    end
    nxt_reload_low_byte = reload_low_byte_ff;
    nxt_reload_high_byte = reload_high_byte_ff;
    if (sfr_wr && sfr_addr == ADDR_RELOAD_LOW) begin
      nxt_reload_low_byte = sfr_wdata;
    end
    if (sfr_wr && sfr_addr == ADDR_RELOAD_HIGH) begin
      nxt_reload_high_byte = sfr_wdata;
    end
    nxt_run_control = wr_ctrl ? sfr_wdata[BIT_RUN_CONTROL] : run_control_ff;
    nxt_prescale_select = wr_ctrl ? sfr_wdata[BIT_PRESCALE_SELECT] : prescale_select_ff;
    nxt_external_clock_select = wr_ctrl ? sfr_wdata[BIT_EXTERNAL_CLOCK_SELECT] :
                                external_clock_select_ff;
    // set beats a same-cycle software clear
    nxt_overflow_flag = wrap | (wr_ctrl ? sfr_wdata[BIT_OVERFLOW_FLAG] :
                        overflow_flag_ff);
    nxt_overflow_pulse = wrap;
    nxt_rdata = rdata_ff;
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_CONTROL: nxt_rdata = ctrl_view;
        ADDR_RELOAD_LOW: nxt_rdata = reload_low_byte_ff;
        ADDR_RELOAD_HIGH: nxt_rdata = reload_high_byte_ff;
        ADDR_COUNT_LOW: nxt_rdata = count_ff[7:0];
        ADDR_COUNT_HIGH: nxt_rdata = count_ff[15:8];
        default: nxt_rdata = UNMAPPED_READ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= {RESET_BYTE, RESET_BYTE};
      reload_low_byte_ff <= RESET_BYTE;
      reload_high_byte_ff <= RESET_BYTE;
      overflow_flag_ff <= RESET_CONTROL[BIT_OVERFLOW_FLAG];
      run_control_ff <= RESET_CONTROL[BIT_RUN_CONTROL];
      prescale_select_ff <= RESET_CONTROL[BIT_PRESCALE_SELECT];
      external_clock_select_ff <= RESET_CONTROL[BIT_EXTERNAL_CLOCK_SELECT];
      div12_ff <= 8'h00;
      div8_ff <= 8'h00;
      overflow_pulse_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      count_ff <= nxt_count;
      reload_low_byte_ff <= nxt_reload_low_byte;
      reload_high_byte_ff <= nxt_reload_high_byte;
      overflow_flag_ff <= nxt_overflow_flag;
      run_control_ff <= nxt_run_control;
      prescale_select_ff <= nxt_prescale_select;
      external_clock_select_ff <= nxt_external_clock_select;
      div12_ff <= nxt_div12;
      div8_ff <= nxt_div8;
      overflow_pulse_ff <= nxt_overflow_pulse;
      rdata_ff <= nxt_rdata;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign overflow_pulse = overflow_pulse_ff;
  assign overflow_flag = overflow_flag_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic cnt_wr;
  assign cnt_wr = wr_cnt_lo | wr_cnt_hi;

  a_reload_on_wrap: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wrap && !cnt_wr && !sfr_wr) |=> count_ff == {$past(reload_high_byte_ff),
    $past(reload_low_byte_ff)})
    else $error("counter not reloaded on wrap");

  a_flag_and_pulse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wrap |=> overflow_flag_ff && overflow_pulse_ff)
    else $error("overflow flag or pulse wrong");

  a_pulse_only_wrap: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !wrap |=> !overflow_pulse_ff)
    else $error("overflow pulse without wrap");

  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (overflow_flag_ff && !wr_ctrl) |=> overflow_flag_ff)
    else $error("overflow flag cleared by hardware");

  a_stop_holds: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!run_control_ff && !cnt_wr) |=> $stable(count_ff))
    else $error("counter moved while stopped");

  a_direct_clock: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (run_control_ff && prescale_select_ff && !external_clock_select_ff && !cnt_wr
     && count_ff != 16'hFFFF) |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("direct clock did not count");

  a_div12_period: assert property (@(posedge ref_clk) disable iff (!rst_b)
    div12_tick |-> ##1 !div12_tick [*8] ##1 !div12_tick [*3] ##1 div12_tick)
    else $error("divide by twelve period wrong");

  a_ext_ignores_sys: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (external_clock_select_ff && !ext_tick && !cnt_wr) |=> $stable(count_ff))
    else $error("external mode counted without oscillator tick");

  a_ext_spacing: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ext_tick |=> !ext_tick [*8])
    else $error("oscillator ticks too close");

  a_unused_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (sfr_rd && sfr_addr == ADDR_CONTROL) |=> sfr_rdata[6:3] == 4'h0)
    else $error("unused control bits not zero");

  a_count_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (run_control_ff && tick && !wrap && !cnt_wr) |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("counter did not step on tick");

  a_reload_low_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (sfr_wr && sfr_addr == ADDR_RELOAD_LOW) |=> reload_low_byte_ff == $past(sfr_wdata))
    else $error("reload low byte not written");

  a_reload_high_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (sfr_wr && sfr_addr == ADDR_RELOAD_HIGH) |=> reload_high_byte_ff == $past(sfr_wdata))
    else $error("reload high byte not written");

  a_rdata_holds: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");

endmodule : auto_reload_timer

// ### hdl/reload_timer_pkg.sv
// Notes on behaviour
// - sixteen-bit up-counter split into two bytes
// - always auto-reload from two reload bytes
// - external select: oscillator divided by eight
// - external select off: prescale bit chooses
// - prescale zero: divide by twelve, one: direct
// - no counter mode, no event pin
// - overflow pulse on its own port; flag on port and bus
// - external input crosses domains safely
package reload_timer_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h95;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_RUN_CONTROL = 2;
  localparam int BIT_PRESCALE_SELECT = 1;
  localparam int BIT_EXTERNAL_CLOCK_SELECT = 0;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_CONTROL = 8'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int SYS_PRESCALE_DIV = 12;
  localparam int EXT_CLOCK_DIV = 8;

endpackage : reload_timer_pkg

// ### bench/auto_reload_timer_bench.sv
`timescale 1ns/100ps
module auto_reload_timer_bench;
  import reload_timer_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic ext_osc = 1'b0;
  logic [7:0] sfr_rdata;
  logic overflow_pulse;
  logic overflow_flag;
  logic [7:0] rv;
  logic [7:0] np;
  logic [1:0] ediv = 2'b00;
  logic [7:0] cv [4] = '{8'h04, 8'h06, 8'h05, 8'h07};
  logic [7:0] lo [4] = '{8'h13, 8'hEE, 8'h06, 8'h06};
  logic [7:0] hi [4] = '{8'h15, 8'hF6, 8'h09, 8'h09};
  int n_mismatch = 0;
  int total_checks = 0;

  auto_reload_timer dut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .ext_osc(ext_osc),
    .overflow_pulse(overflow_pulse),
    .overflow_flag(overflow_flag)
  );

  always #25 ref_clk = ~ref_clk;

  // external oscillator, two cycles per level
  always @(posedge ref_clk) begin
    ediv <= ediv + 2'h1;
    ext_osc <= ediv[1];
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    #1 rv = sfr_rdata;
  endtask : rd

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int a = 8'h90; a <= 8'h95; a++) begin
      rd(8'(a));
      chk("reset value", rv, 8'h00);
    end
    $display("test reset values done");
    wr(ADDR_CONTROL, 8'h78);
    rd(ADDR_CONTROL);
    chk("control unused bits", rv, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h34);
    wr(ADDR_COUNT_HIGH, 8'h12);
    repeat (30) @(posedge ref_clk);
    rd(ADDR_COUNT_LOW);
    chk("stopped count low", rv, 8'h34);
    rd(ADDR_COUNT_HIGH);
    chk("stopped count high", rv, 8'h12);
    $display("test stopped timer done");
    wr(ADDR_RELOAD_LOW, 8'hFE);
    wr(ADDR_RELOAD_HIGH, 8'hFF);
    rd(ADDR_RELOAD_LOW);
    chk("reload low readback", rv, 8'hFE);
    rd(ADDR_RELOAD_HIGH);
    chk("reload high readback", rv, 8'hFF);
    wr(ADDR_COUNT_LOW, 8'hFE);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_CONTROL, 8'h06);
    np = 8'h00;
    repeat (20) begin
      @(posedge ref_clk);
      #1 np = np + {7'h00, overflow_pulse === 1'b1};
    end
    chk("overflow pulses", np, 8'h0A);
    chk("flag port", {7'h00, overflow_flag}, 8'h01);
    wr(ADDR_CONTROL, 8'h80);
    rd(ADDR_CONTROL);
    chk("sticky flag", rv, 8'h80);
    rd(ADDR_COUNT_HIGH);
    chk("reloaded high", rv, 8'hFF);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL);
    chk("flag cleared", rv, 8'h00);
    chk("flag port clear", {7'h00, overflow_flag}, 8'h00);
    $display("test overflow done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'h00);
      wr(ADDR_CONTROL, cv[i]);
      repeat (240) @(posedge ref_clk);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_COUNT_LOW);
      chk("tick rate", {7'h00, rv >= lo[i] && rv <= hi[i]}, 8'h01);
    end
    $display("test clock sources done");
    finish_test();
  end
endmodule : auto_reload_timer_bench
